// ---- inc/pdt_pkg.sv ----
package pdt_pkg;
    // command codes on the configuration port
    localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
    localparam logic [7:0] CMD_STORE_ALL      = 8'h11;
    localparam logic [7:0] CMD_RESTORE_ALL    = 8'h12;
    localparam logic [7:0] CMD_TMO_REACTION   = 8'h63;
    localparam logic [7:0] CMD_SHUTDOWN_WAIT  = 8'h64;
    localparam logic [7:0] CMD_SHUTDOWN_RAMP  = 8'h65;
    // startup timeout reaction byte layout
    localparam int         POLICY_BIT         = 7;
    localparam int         RETRY_HI           = 5;
    localparam int         RETRY_LO           = 3;
    localparam logic [2:0] RESTART_MULT_CODE  = 3'h7;
    localparam logic [2:0] RETRY_NONE         = 3'h0;
    localparam logic [2:0] RETRY_ALWAYS       = 3'h7;
    localparam logic       POLICY_RESET       = 1'h1;
    // timing registers: fixed exponent, 7 writable mantissa bits
    localparam int         MANT_W             = 7;
    localparam logic [8:0] TIME_UPPER_FIXED   = 9'h000;
    localparam logic [6:0] MANT_RESET         = 7'h00;
    // bucket table: mantissa upper bound and resulting milliseconds
    localparam int         NBKT               = 10;
    localparam logic [6:0] BKT_HI [NBKT]      = '{7'h06, 7'h09, 7'h0C, 7'h11, 7'h16,
                                                   7'h20, 7'h2C, 7'h3E, 7'h56, 7'h7F};
    localparam logic [6:0] BKT_MS [NBKT]      = '{7'h00, 7'h07, 7'h0A, 7'h0E, 7'h13,
                                                   7'h1B, 7'h25, 7'h34, 7'h48, 7'h64};
    localparam logic [6:0] FALL_MIN_MS        = 7'h01;
    // time base
    localparam int         CLK_PERIOD_NS      = 10;
    localparam int         MS_NS              = 1000000;
    localparam int         MS_CYCLES          = MS_NS / CLK_PERIOD_NS;
    localparam int         PRE_W              = 20;
    localparam int         MS_W               = 10;
    localparam logic [9:0] RESTART_MULT       = 10'h007;
    typedef enum logic [2:0] {
        PDT_OFF, PDT_ON, PDT_WAIT, PDT_FALL, PDT_LATCH, PDT_RETRY
    } pdt_state_type;
endpackage

// ---- inc/pdt_map_if.sv ----
`timescale 1ns/1ps
interface pdt_map_if;
    logic [6:0] mant [2];
    logic [6:0] ms   [2];
    modport mapper (input mant, output ms);
    modport user   (output mant, input ms);
endinterface

// ---- logic/pdt_bucket_map.sv ----
`timescale 1ns/1ps
module pdt_bucket_map (
    pdt_map_if.mapper m
);
    import pdt_pkg::*;

    // channel 0 is the wait, channel 1 the ramp with its 1 ms floor
    for (genvar i = 0; i < 2; i++) begin : g_chan
        always_comb begin
            logic found;
            found = 1'b0;
            m.ms[i] = BKT_MS[NBKT-1];
            if (m.mant[i] == 7'h00) begin
                m.ms[i] = (i == 1) ? FALL_MIN_MS : 7'h00;
                found = 1'b1;
            end
            for (int k = 0; k < NBKT; k++) begin
                if (!found && m.mant[i] <= BKT_HI[k]) begin
                    m.ms[i] = (k == 0) ? m.mant[i] : BKT_MS[k];
                    found = 1'b1;
                end
            end
        end
    end
endmodule

// ---- logic/pdt_shutdown_cfg.sv ----
`timescale 1ns/1ps
// Contract
// - policy clear: timeout ignored, keep regulating
// - ignore mode still flags and alerts
// - policy set (default): shut down, follow retry
// - retry 000: stay off until cleared
// - retry 111: soft start again, unlimited
// - retry field resets to 111
// - bad retry code: discard, flag, alert
// - store bit 5, replicate on restore
// - wait from stop to ramp start
// - fixed exponent, seven writable mantissa bits
// - timing mantissas reset to zero
// - sixteen supported delay values
// - delay bucket mapping table
// - ramp time from wait end to zero
// - ramp zero or one gives 1 ms
// - store command saves timing settings
// - timeout sets status, asserts alert
// - reaction low bits read 0x7
module pdt_shutdown_cfg #(
    parameter int CYC_PER_MS = pdt_pkg::MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        run_cmd,
    input  wire logic        startup_timeout_fault,
    input  wire logic        tmo_alert_mask,
    input  wire logic [6:0]  startup_ramp_ms,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             output_enable,
    output logic             ramp_down_active,
    output logic             soft_start_go,
    output logic             startup_timeout_flag,
    output logic             cml_flag,
    output logic             invalid_data_flag,
    output logic             smb_alert_out,
    output logic             smb_alert_oe
);
    import pdt_pkg::*;

    typedef struct packed {
        pdt_state_type    st;
        logic             policy;
        logic [2:0]       retry;
        logic [6:0]       dly;
        logic [6:0]       fall;
        logic             nv_policy;
        logic             nv_retry5;
        logic [6:0]       nv_dly;
        logic [6:0]       nv_fall;
        logic             tmo;
        logic             cml;
        logic             ivd;
        logic [PRE_W-1:0] pre;
        logic [MS_W-1:0]  ms;
        logic [15:0]      rdata;
        logic             rvalid;
        logic             out_en;
        logic             ramp_dn;
        logic             ss_go;
        logic             alert;
        logic [1:0]       run_sy;
        logic [2:0]       flt_sy;
    } pdt_regs_type;

    pdt_regs_type r;
    pdt_regs_type next_r;
    pdt_map_if    map ();
    logic         wr;
    logic         rd;
    logic         fault_evt;
    logic         run;
    logic         tick;
    logic [2:0]   new_retry;
    logic [9:0]   eff_dly;
    logic [9:0]   eff_fall;
    logic [9:0]   restart_ms;
    logic [7:0]   reaction_byte;

    pdt_bucket_map u_map (
        .m (map.mapper)
    );

    // decoded strobes and mapped times
    assign map.mant[0]   = r.dly;
    assign map.mant[1]   = r.fall;
    assign eff_dly       = {3'h0, map.ms[0]};
    assign eff_fall      = {3'h0, map.ms[1]};
    assign restart_ms    = 10'(RESTART_MULT * {3'h0, startup_ramp_ms});
    assign wr            = cmd_valid && cmd_write;
    assign rd            = cmd_valid && !cmd_write;
    assign run           = r.run_sy[1];
    assign fault_evt     = r.flt_sy[1] && !r.flt_sy[2];
    assign tick          = (r.pre == PRE_W'(CYC_PER_MS - 1));
    assign new_retry     = cmd_wdata[RETRY_HI:RETRY_LO];
    assign reaction_byte = {r.policy, 1'b0, r.retry, RESTART_MULT_CODE};

    // next-state logic for registers, flags and the off sequencer
    always_comb begin
        next_r        = r;
        next_r.run_sy = {r.run_sy[0], run_cmd};
        next_r.flt_sy = {r.flt_sy[1:0], startup_timeout_fault};
        next_r.rvalid = rd;
        next_r.ss_go  = 1'b0;
        // millisecond time base
        next_r.pre    = tick ? '0 : r.pre + 1'b1;
        next_r.ms     = tick ? r.ms + 1'b1 : r.ms;
        // register reads
        if (rd) begin
            unique case (cmd_code)
                CMD_TMO_REACTION:  next_r.rdata = {8'h00, reaction_byte};
                CMD_SHUTDOWN_WAIT: next_r.rdata = {TIME_UPPER_FIXED, r.dly};
                CMD_SHUTDOWN_RAMP: next_r.rdata = {TIME_UPPER_FIXED, r.fall};
                default:           next_r.rdata = 16'h0000;
            endcase
        end
        // register writes and memory commands
        if (wr) begin
            unique case (cmd_code)
                CMD_TMO_REACTION: begin
                    if (new_retry == RETRY_NONE || new_retry == RETRY_ALWAYS) begin
                        next_r.policy = cmd_wdata[POLICY_BIT];
                        next_r.retry  = new_retry;
                    end else begin
                        next_r.cml = 1'b1;
                        next_r.ivd = 1'b1;
                    end
                end
                CMD_SHUTDOWN_WAIT: next_r.dly  = cmd_wdata[MANT_W-1:0];
                CMD_SHUTDOWN_RAMP: next_r.fall = cmd_wdata[MANT_W-1:0];
                CMD_STORE_ALL: begin
                    next_r.nv_policy = r.policy;
                    next_r.nv_retry5 = r.retry[2];
                    next_r.nv_dly    = r.dly;
                    next_r.nv_fall   = r.fall;
                end
                CMD_RESTORE_ALL: begin
                    next_r.policy = r.nv_policy;
                    next_r.retry  = {3{r.nv_retry5}};
                    next_r.dly    = r.nv_dly;
                    next_r.fall   = r.nv_fall;
                end
                CMD_CLEAR_FAULTS: begin
                    next_r.tmo = 1'b0;
                    next_r.cml = 1'b0;
                    next_r.ivd = 1'b0;
                end
                default: ;
            endcase
        end
        // timeout flag is set in every policy; set wins over clear
        if (fault_evt) begin
            next_r.tmo = 1'b1;
        end
        // sequencer
        unique case (r.st)
            PDT_OFF: begin
                next_r.out_en  = 1'b0;
                next_r.ramp_dn = 1'b0;
                if (run) begin
                    next_r.ss_go  = 1'b1;
                    next_r.out_en = 1'b1;
                    next_r.st     = PDT_ON;
                end
            end
            PDT_ON: begin
                if (!run) begin
                    next_r.st  = PDT_WAIT;
                    next_r.pre = '0;
                    next_r.ms  = '0;
                end else if (fault_evt && r.policy) begin
                    next_r.out_en = 1'b0;
                    next_r.pre    = '0;
                    next_r.ms     = '0;
                    next_r.st     = (r.retry == RETRY_NONE) ? PDT_LATCH : PDT_RETRY;
                end
            end
            PDT_WAIT: begin
                if (r.ms >= eff_dly) begin
                    next_r.st      = PDT_FALL;
                    next_r.ramp_dn = 1'b1;
                    next_r.pre     = '0;
                    next_r.ms      = '0;
                end
            end
            PDT_FALL: begin
                if (r.ms >= eff_fall) begin
                    next_r.st      = PDT_OFF;
                    next_r.ramp_dn = 1'b0;
                    next_r.out_en  = 1'b0;
                end
            end
            PDT_LATCH: begin
                next_r.out_en = 1'b0;
                if (!run || (wr && cmd_code == CMD_CLEAR_FAULTS)) begin
                    next_r.st = PDT_OFF;
                end
            end
            PDT_RETRY: begin
                if (!run) begin
                    next_r.st = PDT_OFF;
                end else if (r.ms >= restart_ms) begin
                    next_r.ss_go  = 1'b1;
                    next_r.out_en = 1'b1;
                    next_r.st     = PDT_ON;
                end
            end
        endcase
        // open-drain alert pulled low while any unmasked source is set
        next_r.alert = (next_r.tmo && !tmo_alert_mask) || next_r.cml;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r           <= '0;
            r.st        <= PDT_OFF;
            r.policy    <= POLICY_RESET;
            r.retry     <= RETRY_ALWAYS;
            r.dly       <= MANT_RESET;
            r.fall      <= MANT_RESET;
            r.nv_policy <= POLICY_RESET;
            r.nv_retry5 <= 1'b1;
            r.nv_dly    <= MANT_RESET;
            r.nv_fall   <= MANT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops, except smb_alert_out which is tied low
    assign rd_data              = r.rdata;
    assign rd_valid             = r.rvalid;
    assign output_enable        = r.out_en;
    assign ramp_down_active     = r.ramp_dn;
    assign soft_start_go        = r.ss_go;
    assign startup_timeout_flag = r.tmo;
    assign cml_flag             = r.cml;
    assign invalid_data_flag    = r.ivd;
    assign smb_alert_out        = 1'b0;
    assign smb_alert_oe         = r.alert;

    // checks
    property p_ignore_keeps_on;
        @(posedge clk) disable iff (!rst_n)
        (r.st == PDT_ON && run && fault_evt && !r.policy) |=> (r.st == PDT_ON && r.out_en);
    endproperty
    a_ignore_keeps_on: assert property (p_ignore_keeps_on)
        else $error("ignore mode left regulation");

    property p_flag_alert;
        @(posedge clk) disable iff (!rst_n)
        (fault_evt && !tmo_alert_mask) |=> (r.tmo && smb_alert_oe);
    endproperty
    a_flag_alert: assert property (p_flag_alert)
        else $error("timeout did not flag and alert");

    property p_shutdown;
        @(posedge clk) disable iff (!rst_n)
        (r.st == PDT_ON && run && fault_evt && r.policy) |=> !output_enable;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("no shutdown on timeout");

    property p_latch_off;
        @(posedge clk) disable iff (!rst_n)
        (r.st == PDT_LATCH && run && !wr) |=> (!output_enable && r.st == PDT_LATCH);
    endproperty
    a_latch_off: assert property (p_latch_off)
        else $error("latched off left early");

    property p_retry_start;
        @(posedge clk) disable iff (!rst_n)
        (r.st == PDT_RETRY && run && r.ms >= restart_ms) |=> (soft_start_go && output_enable);
    endproperty
    a_retry_start: assert property (p_retry_start)
        else $error("retry did not restart");

    property p_bad_retry;
        @(posedge clk) disable iff (!rst_n)
        (wr && cmd_code == CMD_TMO_REACTION && new_retry != RETRY_NONE
            && new_retry != RETRY_ALWAYS) |=> (r.ivd && r.cml && $stable(r.retry));
    endproperty
    a_bad_retry: assert property (p_bad_retry)
        else $error("bad retry code not rejected");

    property p_restore_rep;
        @(posedge clk) disable iff (!rst_n)
        (wr && cmd_code == CMD_RESTORE_ALL) |=> (r.retry == {3{$past(r.nv_retry5)}});
    endproperty
    a_restore_rep: assert property (p_restore_rep)
        else $error("retry not replicated on restore");

    property p_wait_len;
        @(posedge clk) disable iff (!rst_n)
        (r.st == PDT_WAIT ##1 r.st == PDT_FALL) |-> ($past(r.ms) >= eff_dly);
    endproperty
    a_wait_len: assert property (p_wait_len)
        else $error("ramp started before wait ended");

    property p_read_upper;
        @(posedge clk) disable iff (!rst_n)
        (rd && (cmd_code == CMD_SHUTDOWN_WAIT || cmd_code == CMD_SHUTDOWN_RAMP))
            |=> (rd_valid && rd_data[15:7] == TIME_UPPER_FIXED);
    endproperty
    a_read_upper: assert property (p_read_upper)
        else $error("fixed timing bits not zero");

    property p_map_top;
        @(posedge clk) disable iff (!rst_n)
        (r.dly > BKT_HI[NBKT-2]) |-> (eff_dly == {3'h0, BKT_MS[NBKT-1]});
    endproperty
    a_map_top: assert property (p_map_top)
        else $error("top delay bucket wrong");

    property p_fall_min;
        @(posedge clk) disable iff (!rst_n)
        (r.fall <= 7'h01) |-> (eff_fall == {3'h0, FALL_MIN_MS});
    endproperty
    a_fall_min: assert property (p_fall_min)
        else $error("ramp floor not 1 ms");

    property p_store;
        @(posedge clk) disable iff (!rst_n)
        (wr && cmd_code == CMD_STORE_ALL) |=> (r.nv_dly == $past(r.dly)
            && r.nv_fall == $past(r.fall));
    endproperty
    a_store: assert property (p_store)
        else $error("timing not stored");
endmodule

// ---- tb/pdt_host_model.sv ----
`timescale 1ns/1ps
// host on the command port: one strobe per command, lines released between commands
module pdt_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata
);
    // idle values at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // raised after a falling edge, taken at the next rising edge, then dropped
    task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code  = ~c; // released lines no longer show the last value
        cmd_wdata = ~d;
    endtask

    // the bench only hands 000 or 111 retry codes unless a refusal is wanted
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        issue(1'b1, c, d);
    endtask

    // read answer is waited for under a short bound
    task automatic rd(input logic [7:0] c, output logic [15:0] q, output logic ok);
        int n;
        issue(1'b0, c, 16'h0000);
        n = 0;
        while (rd_valid !== 1'b1 && n < 2) begin
            @(negedge clk);
            n++;
        end
        ok = rd_valid;
        q  = rd_data;
    endtask
endmodule

// ---- tb/pdt_shutdown_cfg_bench.sv ----
`timescale 1ns/1ps
// command sequences and pin stimulus with worked-out expectations
module pdt_shutdown_cfg_bench;
    import pdt_pkg::*;
    localparam int CPM = 10;
    // cycles from run_cmd low to ramp start at zero wait: sync two, leave on, enter ramp
    localparam int OFF_LAT = 4;
    localparam int HI [10] = '{6, 9, 12, 17, 22, 32, 44, 62, 86, 127};
    localparam int MS [10] = '{0, 7, 10, 14, 19, 27, 37, 52, 72, 100};
    localparam int DLY [12] = '{0, 1, 6, 7, 12, 13, 22, 23, 44, 45, 86, 87};
    localparam int FAL [12] = '{0, 1, 2, 6, 7, 9, 10, 17, 18, 62, 63, 86};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        run_cmd = 1'b0;
    logic        tmo = 1'b0;
    logic        mask = 1'b0;
    logic [6:0]  rise_ms = 7'h02;
    logic        cmd_valid, cmd_write, rd_valid, oe, ramp, go;
    logic        tflag, cml, ivd, al_oe, al_out;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, rd_data, q;
    logic        ok;
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n1, n2;

    pdt_shutdown_cfg #(.CYC_PER_MS(CPM)) dut_u (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .run_cmd(run_cmd),
        .startup_timeout_fault(tmo), .tmo_alert_mask(mask), .startup_ramp_ms(rise_ms),
        .rd_data(rd_data), .rd_valid(rd_valid), .output_enable(oe),
        .ramp_down_active(ramp), .soft_start_go(go), .startup_timeout_flag(tflag),
        .cml_flag(cml), .invalid_data_flag(ivd), .smb_alert_out(al_out),
        .smb_alert_oe(al_oe));

    pdt_host_model host_u (
        .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    always #5 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    // milliseconds chosen for a programmed mantissa
    function automatic int eff(input int m);
        for (int i = 0; i < 10; i++) begin
            if (m <= HI[i]) return (i == 0) ? m : MS[i];
        end
        return 100;
    endfunction

    task automatic chk(input logic c, input string msg);
        n_checks++;
        if (c !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // timeout event held long enough for the pin synchroniser
    task automatic tmo_pulse();
        @(negedge clk);
        tmo = 1'b1;
        settle(3);
        tmo = 1'b0;
    endtask

    // one on/off cycle: n1 = cycles to ramp start, n2 = ramp length
    task automatic run_off(input int m, input int f);
        host_u.wr(CMD_SHUTDOWN_WAIT, 16'(m));
        host_u.wr(CMD_SHUTDOWN_RAMP, 16'(f));
        run_cmd = 1'b1;
        settle(10);
        chk(oe === 1'b1, "output not enabled");
        run_cmd = 1'b0;
        n1 = 0;
        n2 = 0;
        while (ramp !== 1'b1 && n1 < 2000) begin
            settle(1);
            n1++;
        end
        while (ramp === 1'b1 && n2 < 2000) begin
            settle(1);
            n2++;
        end
        settle(3);
        chk(oe === 1'b0, "output still on after ramp");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        settle(2);
        rst_n = 1'b1;
        // reset values, masking of fixed bits, unmapped place
        host_u.rd(CMD_TMO_REACTION, q, ok);
        chk(ok === 1'b1 && q === 16'h00BF, "reaction reset");
        host_u.rd(CMD_SHUTDOWN_WAIT, q, ok);
        chk(ok === 1'b1 && q === 16'h0000, "wait reset");
        host_u.rd(CMD_SHUTDOWN_RAMP, q, ok);
        chk(ok === 1'b1 && q === 16'h0000, "ramp reset");
        host_u.rd(8'h99, q, ok);
        chk(q === 16'h0000, "unmapped read");
        host_u.wr(CMD_SHUTDOWN_WAIT, 16'hFFFF);
        host_u.rd(CMD_SHUTDOWN_WAIT, q, ok);
        chk(q === 16'h007F, "wait fixed bits");
        host_u.wr(CMD_SHUTDOWN_RAMP, 16'hFF80);
        host_u.rd(CMD_SHUTDOWN_RAMP, q, ok);
        chk(q === 16'h0000, "ramp fixed bits");
        host_u.wr(CMD_TMO_REACTION, 16'hFFFF);
        host_u.rd(CMD_TMO_REACTION, q, ok);
        chk(q === 16'h00BF, "reaction fixed bits");
        // every refused retry code
        for (int r = 1; r < 7; r++) begin
            host_u.wr(CMD_TMO_REACTION, {8'h00, 2'b00, 3'(r), 3'b000});
            chk(cml === 1'b1 && ivd === 1'b1 && al_oe === 1'b1, "bad code not flagged");
            host_u.rd(CMD_TMO_REACTION, q, ok);
            chk(q === 16'h00BF, "bad code not discarded");
            host_u.wr(CMD_CLEAR_FAULTS, 16'h0000);
            chk(cml === 1'b0 && ivd === 1'b0 && al_oe === 1'b0, "clear failed");
        end
        // wait and ramp buckets, boundaries on each side
        for (int i = 0; i < 12; i++) begin
            run_off(DLY[i], FAL[i]);
            chk(n1 == OFF_LAT + eff(DLY[i]) * CPM, "wait bucket");
            n2 = n2 - ((FAL[i] <= 1) ? 1 : eff(FAL[i])) * CPM;
            chk(n2 >= -1 && n2 <= 1, "ramp bucket");
        end
        // ignore mode: stays on, still flags and alerts unless masked
        // short off sequence so later scenarios are not stuck behind a 100 ms wait
        host_u.wr(CMD_SHUTDOWN_WAIT, 16'h0000);
        host_u.wr(CMD_SHUTDOWN_RAMP, 16'h0000);
        host_u.wr(CMD_TMO_REACTION, 16'h0007);
        run_cmd = 1'b1;
        settle(10);
        tmo_pulse();
        settle(6);
        chk(oe === 1'b1 && tflag === 1'b1 && al_oe === 1'b1, "ignore mode");
        host_u.wr(CMD_CLEAR_FAULTS, 16'h0000);
        mask = 1'b1;
        tmo_pulse();
        settle(6);
        chk(tflag === 1'b1 && al_oe === 1'b0 && al_out === 1'b0, "masked alert");
        mask = 1'b0;
        host_u.wr(CMD_CLEAR_FAULTS, 16'h0000);
        // shut down and latch off
        host_u.wr(CMD_TMO_REACTION, 16'h0087);
        tmo_pulse();
        settle(6);
        chk(oe === 1'b0, "no shutdown");
        settle(300);
        chk(oe === 1'b0 && tflag === 1'b1, "latched output restarted");
        host_u.wr(CMD_CLEAR_FAULTS, 16'h0000);
        run_cmd = 1'b0;
        settle(30);
        // unlimited retry after seven rise times
        host_u.wr(CMD_TMO_REACTION, 16'h00BF);
        run_cmd = 1'b1;
        settle(10);
        for (int k = 0; k < 2; k++) begin
            tmo_pulse();
            n1 = 0;
            while (go !== 1'b1 && n1 < 400) begin
                settle(1);
                n1++;
            end
            chk(n1 >= 134 && n1 <= 146, "retry delay");
        end
        run_cmd = 1'b0;
        settle(30);
        // store then restore
        host_u.wr(CMD_SHUTDOWN_WAIT, 16'h0022);
        host_u.wr(CMD_SHUTDOWN_RAMP, 16'h0041);
        host_u.wr(CMD_TMO_REACTION, 16'h0007);
        host_u.wr(CMD_STORE_ALL, 16'h0000);
        host_u.wr(CMD_SHUTDOWN_WAIT, 16'h0005);
        host_u.wr(CMD_SHUTDOWN_RAMP, 16'h0005);
        host_u.wr(CMD_TMO_REACTION, 16'h00BF);
        host_u.wr(CMD_RESTORE_ALL, 16'h0000);
        host_u.rd(CMD_SHUTDOWN_WAIT, q, ok);
        chk(q === 16'h0022, "wait restore");
        host_u.rd(CMD_SHUTDOWN_RAMP, q, ok);
        chk(q === 16'h0041, "ramp restore");
        host_u.rd(CMD_TMO_REACTION, q, ok);
        chk(q === 16'h0007, "reaction restore");
        wrap_up();
    end
endmodule
